// file: memory_block_select_decoder_params.svh
// Address map, field positions and reset values for the block select decoder
`ifndef MEMORY_BLOCK_SELECT_DECODER_PARAMS_SVH
`define MEMORY_BLOCK_SELECT_DECODER_PARAMS_SVH

`define LOW_SPACE_MSB 12
`define BLOCK_FIELD_MSB 12
`define BLOCK_FIELD_LSB 10
`define PORT_A_PIN_DATA_OFFSET 13'h1700
`define PORT_A_DIRECTION_OFFSET 13'h1701
`define PORT_A_DATA_RESET 8'h00
`define PORT_A_DIRECTION_RESET 8'h00
`define SELECT_ALL_OFF 8'hff
`define READ_DATA_RESET 8'h00
`define DISPLAY_ADDR_RESET 16'h0000

`endif

// file: memory_block_select_decoder_pkg.sv
// Types used by the block select decoder for read data and monitor state
package memory_block_select_decoder_pkg;

  typedef logic [7:0] data_byte_t;

  typedef enum logic [1:0] {
    MON_IDLE = 2'b00,
    MON_RUN = 2'b01,
    MON_STEP_FIRST = 2'b10,
    MON_STEP_NEXT = 2'b11
  } monitor_state_t;

endpackage

// file: port_a_unit.sv
// Memory-mapped port A: data and direction registers with pin synchronisers
`timescale 1ns/1ps
`default_nettype none
`include "memory_block_select_decoder_params.svh"

module port_a_unit (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_data_write,
  input wire logic i_direction_write,
  input wire logic [7:0] i_wr_data,
  input wire logic [7:0] i_pin,
  output logic [7:0] o_pin_level,
  output logic [7:0] o_direction,
  output logic [7:0] o_pin_out,
  output logic [7:0] o_pin_oe
);

  logic [7:0] sync1_reg;
  logic [7:0] sync2_reg;
  logic [7:0] sync3_reg;
  logic [7:0] level_reg;
  logic [7:0] data_reg;
  logic [7:0] direction_reg;
  logic [7:0] data_next;

  // Written bits land only on output pins; input bits keep their old value
  assign data_next = (i_wr_data & direction_reg) | (data_reg & ~direction_reg);

  // Three-stage pin capture; a bit changes once stages two and three agree
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      sync1_reg <= 8'h00;
      sync2_reg <= 8'h00;
      sync3_reg <= 8'h00;
    end else begin
      sync1_reg <= i_pin;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  // Per-bit agreement filter
  genvar b;
  generate
    for (b = 0; b < 8; b = b + 1) begin : g_filter
      always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
          level_reg[b] <= 1'b0;
        end else if (sync2_reg[b] == sync3_reg[b]) begin
          level_reg[b] <= sync3_reg[b];
        end
      end
    end
  endgenerate

  // Data and direction registers, one bit per pin
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      data_reg <= `PORT_A_DATA_RESET;
      direction_reg <= `PORT_A_DIRECTION_RESET;
    end else begin
      if (i_data_write) begin
        data_reg <= data_next;
      end
      if (i_direction_write) begin
        direction_reg <= i_wr_data;
      end
    end
  end

  assign o_pin_level = level_reg;
  assign o_direction = direction_reg;
  assign o_pin_out = data_reg;
  assign o_pin_oe = direction_reg;

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);

  AST_PORT_WRITE_OUTPUTS: assert property (
    i_data_write && !i_direction_write |=>
      ((o_pin_out & o_pin_oe) == ($past(i_wr_data) & o_pin_oe)))
    else $error("Output pins did not take written data");

  AST_PORT_INPUTS_HOLD: assert property (
    i_data_write && !i_direction_write |=>
      ((o_pin_out & ~o_pin_oe) == ($past(o_pin_out) & ~o_pin_oe)))
    else $error("Input pins changed on a data write");

  AST_DIRECTION_SET: assert property (
    i_direction_write |=> o_pin_oe == $past(i_wr_data))
    else $error("Direction register did not follow the write");

  AST_PIN_FOLLOWS: assert property (
    $stable(i_pin) [*4] |=> o_pin_level == $past(i_pin, 4))
    else $error("Pin level not reflected after settling");

endmodule
`default_nettype wire

// file: memory_block_select_decoder.sv
// Low-space block select decoder with port A and monitor step and stop control
`timescale 1ns/1ps
`default_nettype none
`include "memory_block_select_decoder_params.svh"

module memory_block_select_decoder (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic [15:0] i_addr,
  input wire logic [7:0] i_wr_data,
  input wire logic [7:0] i_bus_data,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic i_decoder_enable_n,
  input wire logic [7:0] i_port_a_pin,
  input wire logic i_single_step_switch,
  input wire logic i_stop_key,
  input wire logic i_go,
  input wire logic i_opcode_fetch,
  output logic [7:0] o_block_select_n,
  output logic [7:0] o_rd_data,
  output logic [7:0] o_port_a_out,
  output logic [7:0] o_port_a_oe,
  output logic o_user_running,
  output logic o_monitor_return,
  output logic [15:0] o_display_addr,
  output logic [7:0] o_display_data
);

  memory_block_select_decoder_pkg::monitor_state_t state_reg;
  memory_block_select_decoder_pkg::monitor_state_t state_next;
  memory_block_select_decoder_pkg::data_byte_t rd_data_next;
  logic [7:0] select_n_reg;
  logic [7:0] select_n_next;
  logic [7:0] rd_data_reg;
  logic [15:0] display_addr_reg;
  logic [7:0] display_data_reg;
  logic monitor_return_reg;
  logic user_running_reg;
  logic [1:0] key_sync1_reg;
  logic [1:0] key_sync2_reg;
  logic [1:0] key_sync3_reg;
  logic [1:0] key_level_reg;
  logic stop_level_prev_reg;
  logic stop_pending_reg;
  logic decoder_enabled;
  logic [2:0] block_index;
  logic [12:0] low_addr;
  logic port_data_hit;
  logic port_direction_hit;
  logic stop_press;
  logic halt_now;
  logic step_switch_on;
  logic [7:0] pin_level;
  logic [7:0] direction;

  // Low decoder: high address bits never reach it, only the enable does
  assign decoder_enabled = ~i_decoder_enable_n;
  assign block_index = i_addr[`BLOCK_FIELD_MSB:`BLOCK_FIELD_LSB];
  assign low_addr = i_addr[`LOW_SPACE_MSB:0];

  // Active-low one-hot selects, all high while disabled
  genvar k;
  generate
    for (k = 0; k < 8; k = k + 1) begin : g_select
      assign select_n_next[k] = ~(decoder_enabled && (block_index == 3'(k)));
    end
  endgenerate

  // Port registers are plain memory locations inside block five
  assign port_data_hit = decoder_enabled && (low_addr == `PORT_A_PIN_DATA_OFFSET);
  assign port_direction_hit = decoder_enabled && (low_addr == `PORT_A_DIRECTION_OFFSET);

  // Read mux: pins for the data register, the direction register, else zero
  assign rd_data_next = port_data_hit ? pin_level :
                        (port_direction_hit ? direction : `READ_DATA_RESET);

  // Select outputs and read data are registered
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      select_n_reg <= `SELECT_ALL_OFF;
      rd_data_reg <= `READ_DATA_RESET;
    end else begin
      select_n_reg <= select_n_next;
      if (i_read) begin
        rd_data_reg <= rd_data_next;
      end
    end
  end

  port_a_unit port_a_unit_inst (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_data_write(i_write && port_data_hit),
    .i_direction_write(i_write && port_direction_hit),
    .i_wr_data(i_wr_data),
    .i_pin(i_port_a_pin),
    .o_pin_level(pin_level),
    .o_direction(direction),
    .o_pin_out(o_port_a_out),
    .o_pin_oe(o_port_a_oe)
  );

  // Switch and stop key: three stages, change accepted when two and three agree
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      key_sync1_reg <= 2'h0;
      key_sync2_reg <= 2'h0;
      key_sync3_reg <= 2'h0;
    end else begin
      key_sync1_reg <= {i_stop_key, i_single_step_switch};
      key_sync2_reg <= key_sync1_reg;
      key_sync3_reg <= key_sync2_reg;
    end
  end

  generate
    for (k = 0; k < 2; k = k + 1) begin : g_key_filter
      always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
          key_level_reg[k] <= 1'b0;
        end else if (key_sync2_reg[k] == key_sync3_reg[k]) begin
          key_level_reg[k] <= key_sync3_reg[k];
        end
      end
    end
  endgenerate

  assign step_switch_on = key_level_reg[0];
  assign stop_press = key_level_reg[1] && !stop_level_prev_reg;

  // Halt at the next opcode fetch: stop pending in run, or second fetch of a step
  assign halt_now = i_opcode_fetch &&
                    (((state_reg == memory_block_select_decoder_pkg::MON_RUN) &&
                      stop_pending_reg) ||
                     (state_reg == memory_block_select_decoder_pkg::MON_STEP_NEXT));

  // Monitor control sequence
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      memory_block_select_decoder_pkg::MON_IDLE: begin
        if (i_go) begin
          state_next = step_switch_on ? memory_block_select_decoder_pkg::MON_STEP_FIRST
                                      : memory_block_select_decoder_pkg::MON_RUN;
        end
      end
      memory_block_select_decoder_pkg::MON_RUN: begin
        if (halt_now) begin
          state_next = memory_block_select_decoder_pkg::MON_IDLE;
        end
      end
      memory_block_select_decoder_pkg::MON_STEP_FIRST: begin
        if (i_opcode_fetch) begin
          state_next = memory_block_select_decoder_pkg::MON_STEP_NEXT;
        end
      end
      memory_block_select_decoder_pkg::MON_STEP_NEXT: begin
        if (halt_now) begin
          state_next = memory_block_select_decoder_pkg::MON_IDLE;
        end
      end
    endcase
  end

  // State, pending stop and captured display values
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      state_reg <= memory_block_select_decoder_pkg::MON_IDLE;
      stop_level_prev_reg <= 1'b0;
      stop_pending_reg <= 1'b0;
      monitor_return_reg <= 1'b0;
      user_running_reg <= 1'b0;
      display_addr_reg <= `DISPLAY_ADDR_RESET;
      display_data_reg <= `READ_DATA_RESET;
    end else begin
      state_reg <= state_next;
      stop_level_prev_reg <= key_level_reg[1];
      // A press in the halting cycle wins over the clear, but the flag drops a cycle later once out of run
      if (stop_press && (state_reg == memory_block_select_decoder_pkg::MON_RUN)) begin
        stop_pending_reg <= 1'b1;
      end else if (state_reg != memory_block_select_decoder_pkg::MON_RUN) begin
        stop_pending_reg <= 1'b0;
      end else if (halt_now) begin
        stop_pending_reg <= 1'b0;
      end
      monitor_return_reg <= halt_now;
      // Running flag is registered so the output comes straight from a flop
      user_running_reg <= (state_next != memory_block_select_decoder_pkg::MON_IDLE);
      if (halt_now) begin
        display_addr_reg <= i_addr;
        display_data_reg <= i_bus_data;
      end
    end
  end

  assign o_block_select_n = select_n_reg;
  assign o_rd_data = rd_data_reg;
  assign o_user_running = user_running_reg;
  assign o_monitor_return = monitor_return_reg;
  assign o_display_addr = display_addr_reg;
  assign o_display_data = display_data_reg;

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);

  sequence seq_step_start;
    (state_reg == memory_block_select_decoder_pkg::MON_IDLE) && i_go && step_switch_on;
  endsequence

  AST_ONE_HOT_ENABLED: assert property (
    decoder_enabled |=> $onehot(~o_block_select_n))
    else $error("Enabled decode is not one-hot");

  AST_NONE_DISABLED: assert property (
    !decoder_enabled |=> o_block_select_n == 8'hff)
    else $error("Select asserted while disabled");

  AST_BLOCK_INDEX: assert property (
    decoder_enabled |=> !o_block_select_n[$past(i_addr[12:10])])
    else $error("Wrong block selected");

  AST_HIGH_BITS_IGNORED: assert property (
    decoder_enabled && i_addr[12:10] == 3'h5 |=> o_block_select_n == 8'hdf)
    else $error("High address bits affected low decode");

  AST_PORT_READ: assert property (
    i_read && port_data_hit |=> o_rd_data == $past(pin_level))
    else $error("Port read did not return pin levels");

  AST_STEP_ENTER: assert property (
    seq_step_start |=> state_reg == memory_block_select_decoder_pkg::MON_STEP_FIRST)
    else $error("Go with step switch did not enter step");

  AST_STEP_RETURN: assert property (
    (state_reg == memory_block_select_decoder_pkg::MON_STEP_NEXT) && i_opcode_fetch |=>
      o_monitor_return && !o_user_running && o_display_addr == $past(i_addr))
    else $error("Single step did not return after one instruction");

  AST_STOP_HALT: assert property (
    (state_reg == memory_block_select_decoder_pkg::MON_RUN) && stop_pending_reg &&
      i_opcode_fetch |=> o_monitor_return && o_display_data == $past(i_bus_data) ##1
      !o_monitor_return)
    else $error("Stop did not halt at next fetch");

endmodule
`default_nettype wire

// file: far_side_model.sv
// Far-side model: upper 8K decoder, expansion option and port A pin wiring
`timescale 1ns/1ps
`default_nettype none
module far_side_model (
  input wire logic [2:0] i_high_addr,
  input wire logic i_expanded,
  input wire logic [7:0] i_switches,
  input wire logic [7:0] i_port_a_out,
  input wire logic [7:0] i_port_a_oe,
  output logic [7:0] o_upper_select_n,
  output logic o_low_enable_n,
  output logic [7:0] o_pin_level
);
  // Upper decoder splits the space into eight 8K blocks; unexpanded only block zero
  assign o_upper_select_n = i_expanded ? ~(8'h01 << i_high_addr) : 8'hfe;
  // Block zero output enables the on-board decoder, so when expanded it is off for other blocks
  assign o_low_enable_n = o_upper_select_n[0];
  // A pin shows the device level where it drives and the switch elsewhere
  assign o_pin_level = (i_port_a_out & i_port_a_oe) | (i_switches & ~i_port_a_oe);
endmodule
`default_nettype wire

// file: test_memory_block_select_decoder.sv
// Self-checking bench for the block select decoder
`timescale 1ns/1ps
`default_nettype none
module test_memory_block_select_decoder;
  logic i_clock, i_rst, i_read, i_write, i_single_step_switch, i_stop_key, i_go;
  logic i_opcode_fetch, expanded, seen_ret, low_en_n, o_user_running, o_monitor_return;
  logic [15:0] i_addr, o_display_addr;
  logic [7:0] i_wr_data, i_bus_data, switches, o_block_select_n, o_rd_data;
  logic [7:0] o_port_a_out, o_port_a_oe, o_display_data, upper_n, pins;
  int n_mismatch = 0;
  int checked = 0;
  int cycles = 0;

  memory_block_select_decoder memory_block_select_decoder_inst (
    .i_clock(i_clock), .i_rst(i_rst), .i_addr(i_addr), .i_wr_data(i_wr_data),
    .i_bus_data(i_bus_data), .i_read(i_read), .i_write(i_write),
    .i_decoder_enable_n(low_en_n), .i_port_a_pin(pins),
    .i_single_step_switch(i_single_step_switch), .i_stop_key(i_stop_key), .i_go(i_go),
    .i_opcode_fetch(i_opcode_fetch), .o_block_select_n(o_block_select_n),
    .o_rd_data(o_rd_data), .o_port_a_out(o_port_a_out), .o_port_a_oe(o_port_a_oe),
    .o_user_running(o_user_running), .o_monitor_return(o_monitor_return),
    .o_display_addr(o_display_addr), .o_display_data(o_display_data)
  );

  far_side_model far_side_model_inst (
    .i_high_addr(i_addr[15:13]), .i_expanded(expanded), .i_switches(switches),
    .i_port_a_out(o_port_a_out), .i_port_a_oe(o_port_a_oe),
    .o_upper_select_n(upper_n), .o_low_enable_n(low_en_n), .o_pin_level(pins)
  );

  // Compare one value and count it
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge i_clock);
  endtask

  // Bus cycles: strobe held for one clock, then one idle clock between calls
  task automatic bus_write(input logic [15:0] a, input logic [7:0] d);
    i_addr = a;
    i_wr_data = d;
    i_write = 1'b1;
    cyc(1);
    i_write = 1'b0;
    cyc(1);
  endtask

  task automatic bus_read(input logic [15:0] a, input logic [7:0] exp, input string name);
    i_addr = a;
    i_read = 1'b1;
    cyc(1);
    i_read = 1'b0;
    check(name, {8'h00, o_rd_data}, {8'h00, exp});
    cyc(1);
  endtask

  task automatic fetch(input logic [15:0] a, input logic [7:0] d);
    i_addr = a;
    i_bus_data = d;
    i_opcode_fetch = 1'b1;
    cyc(1);
    i_opcode_fetch = 1'b0;
  endtask

  task automatic go_pulse();
    i_go = 1'b1;
    cyc(1);
    i_go = 1'b0;
    cyc(1);
  endtask

  // Clock
  initial begin
    i_clock = 1'b0;
    forever #25 i_clock = ~i_clock;
  end

  // Hang guard
  always @(posedge i_clock) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      n_mismatch++;
      final_report();
    end
  end

  initial begin
    {i_rst, i_read, i_write, i_single_step_switch, i_stop_key, i_go} = 6'h20;
    {i_opcode_fetch, expanded, seen_ret} = 3'h0;
    {i_addr, i_wr_data, i_bus_data, switches} = 40'h0;
    repeat (6) @(posedge i_clock);
    cyc(1);
    check("selects in reset", {8'h00, o_block_select_n}, 16'h00ff);
    check("oe in reset", {8'h00, o_port_a_oe}, 16'h0000);
    i_rst = 1'b0;
    cyc(4);
    for (int k = 0; k < 8; k++) begin
      i_addr = 16'he000 | 16'(k * 1024) | 16'h03ff;
      cyc(1);
      check("block select", {8'h00, o_block_select_n}, {8'h00, ~(8'h01 << k)});
    end
    expanded = 1'b1;
    i_addr = 16'h2400;
    cyc(1);
    check("upper block", {8'h00, o_block_select_n}, 16'h00ff);
    i_addr = 16'h0400;
    cyc(1);
    check("lowest block", {8'h00, o_block_select_n}, 16'h00fd);
    bus_read(16'hf700, 8'h00, "read off block zero");
    expanded = 1'b0;
    $display("test decoder done");
    switches = 8'ha4;
    bus_write(16'h1701, 8'h01);
    check("direction", {8'h00, o_port_a_oe}, 16'h0001);
    bus_write(16'h1700, 8'hff);
    check("port out", {8'h00, o_port_a_out}, 16'h0001);
    cyc(4);
    bus_read(16'h1700, 8'ha5, "pins");
    bus_write(16'h1700, 8'h00);
    switches = 8'h5b;
    cyc(4);
    bus_read(16'h1700, 8'h5a, "pins follow switches");
    bus_read(16'hf701, 8'h01, "direction alias");
    bus_read(16'h1702, 8'h00, "unmapped");
    bus_read(16'h1701, 8'h01, "direction");
    expanded = 1'b1;
    bus_read(16'hf701, 8'h00, "deselected read");
    expanded = 1'b0;
    check("oe kept", {8'h00, o_port_a_oe}, 16'h0001);
    $display("test port done");
    i_single_step_switch = 1'b1;
    cyc(4); // Switch must pass its synchroniser before go
    go_pulse();
    check("step running", {15'h0, o_user_running}, 16'h0001);
    fetch(16'h0200, 8'ha9);
    cyc(2);
    check("step executes", {15'h0, o_user_running}, 16'h0001);
    fetch(16'h0202, 8'h8d);
    check("step return", {15'h0, o_monitor_return}, 16'h0001);
    check("step stopped", {15'h0, o_user_running}, 16'h0000);
    check("step address", o_display_addr, 16'h0202);
    check("step data", {8'h00, o_display_data}, 16'h008d);
    cyc(1);
    check("return pulse", {15'h0, o_monitor_return}, 16'h0000);
    $display("test step done");
    i_single_step_switch = 1'b0;
    cyc(4); // Switch off must settle so go enters free run
    go_pulse();
    i_stop_key = 1'b1;
    for (int i = 0; i < 12 && !seen_ret; i++) begin
      fetch(16'h0300 + 16'(i), 8'hca);
      if (o_monitor_return === 1'b1) begin
        seen_ret = 1'b1;
        check("stop address", o_display_addr, 16'h0300 + 16'(i));
        check("stop data", {8'h00, o_display_data}, 16'h00ca);
      end
      cyc(1);
    end
    check("stop halted", {15'h0, seen_ret}, 16'h0001);
    i_stop_key = 1'b0;
    $display("test stop done");
    final_report();
  end
endmodule
`default_nettype wire
